/* File: bench/servo_output_status_logic_bench.sv */
// Purpose: Self-checking bench for the servo output status block
// Assumes: 25 MHz clock, one-cycle register read latency
// Notes:   Encoder sweeps use small steps so no quadrature edge is skipped
`timescale 1ns/100ps
module servo_output_status_logic_bench;
   import sos_pkg::*;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic clear = 1'b0;
   sos_req_t bus_req = '0;
   sos_mot_t mot = '0;
   logic [31:0] rdata;
   logic [31:0] v;
   logic output_one, output_two, output_three, output_alarm;
   logic servo_on, motor_power_en;
   logic [2:0] led_color;
   int a_toggles, z_pulses;
   int bad_count = 0;
   int samples_checked = 0;

   always #20 clk_sys = ~clk_sys;

   sos_top u_dut (.clk_sys(clk_sys), .resetn(resetn), .bus_req(bus_req),
      .rdata(rdata), .mot(mot), .output_one(output_one),
      .output_two(output_two), .output_three(output_three),
      .output_alarm(output_alarm), .servo_on(servo_on),
      .motor_power_en(motor_power_en), .led_color(led_color));

   sos_host_model u_host (.clk_sys(clk_sys), .clear(clear),
      .line_a(output_one), .line_z(output_three),
      .a_toggles(a_toggles), .z_pulses(z_pulses));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task test_done;
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done

   task check(input string name, input logic [31:0] seen,
              input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick

   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk_sys);
      bus_req.wr <= 1'b0;
   endtask : wr

   task rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      bus_req <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clk_sys);
      bus_req.rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_reset;
      rd(REG_CTRL, v);
      check("ctrl", v, {27'h0, CTRL_RST});
      rd(REG_INPOS, v);
      check("inpos", v, {16'h0, INPOS_RST});
      rd(REG_MOVE, v);
      check("move", v, {16'h0, MOVE_RST});
      rd(REG_RES, v);
      check("res", v, {16'h0, RES_RST});
      rd(4'hf, v);
      check("unmapped", v, 32'h0);
      check("alarm idle", output_alarm, 1'b0);
   endtask : t_reset

   task set_cond(input int i, input logic on);
      @(posedge clk_sys);
      case (i)
         0: wr(REG_CTRL, {27'h0, 1'b1, on, on, on, 1'b1});
         1: mot.pos_err <= on ? 32'd10 : 32'd11;
         2: mot.limits <= {1'b0, on};
         3: mot.speed <= on ? 16'd101 : 16'd100;
         4: wr(REG_CTRL, {27'h0, on, 3'b000, 1'b1});
         default: mot.torque_in <= on;
      endcase
      tick(3);
   endtask : set_cond

   task t_func;
      logic [3:0] fn [6];
      fn = '{FN_GENERAL, FN_INPOS, FN_WARN, FN_MOVE, FN_SERVO, FN_TORQUE};
      wr(REG_CTRL, 32'h11);
      for (int i = 0; i < 6; i++) begin
         wr(REG_FUNC, {20'h0, 4'h3, fn[i], fn[i]});
         set_cond(i, 1'b0);
         check("output_one off", output_one, 1'b0);
         check("out2 off", output_two, 1'b0);
         set_cond(i, 1'b1);
         check("output_one on", output_one, 1'b1);
         check("out2 on", output_two, 1'b1);
         check("out3 unused", output_three, 1'b0);
         if (i == 2) begin
            rd(REG_CODE, v);
            check("limit code", v, {16'h0, CODE_WARN});
         end
      end
      @(posedge clk_sys);
      mot.limits <= 2'b00;
      mot.speed <= 16'h0;
      mot.torque_in <= 1'b0;
      mot.warn_other <= 2'b10;
      wr(REG_FUNC, {20'h0, 4'h3, FN_WARN, FN_WARN});
      tick(3);
      check("other warn", output_one, 1'b1);
      check("servo on", servo_on, 1'b1);
      @(posedge clk_sys);
      mot.warn_other <= 2'b00;
      tick(3);
      check("warn clear", output_one, 1'b0);
   endtask : t_func

   task t_alarm;
      @(posedge clk_sys);
      mot.alarms <= 6'h21;
      tick(3);
      check("alarm out", output_alarm, 1'b1);
      check("alarm servo", servo_on, 1'b0);
      check("alarm led", (led_color != LED_OFF) && (led_color != LED_BLUE),
            1'b1);
      rd(REG_ALARM, v);
      check("alarm reg", v, 32'h21);
      @(posedge clk_sys);
      mot.alarms <= 6'h00;
      tick(2);
   endtask : t_alarm

   task t_sto;
      @(posedge clk_sys);
      mot.sto_ok <= 1'b0;
      tick(3);
      check("sto servo", servo_on, 1'b0);
      check("sto power", motor_power_en, 1'b0);
      check("sto led", led_color, LED_WHITE);
      rd(REG_CODE, v);
      check("sto code", v, {16'h0, CODE_STO});
      rd(REG_STAT, v);
      check("sto stat", v, 32'h41);
      @(posedge clk_sys);
      mot.sto_ok <= 1'b1;
      tick(3);
      check("restore servo", servo_on, 1'b1);
      check("restore alarm", output_alarm, 1'b0);
      check("restore power", motor_power_en, 1'b1);
   endtask : t_sto

   // One full turn in steps of 4 angle units
   task turn(input logic [31:0] ppr, input int exp_a);
      wr(REG_RES, ppr);
      @(posedge clk_sys);
      clear <= 1'b1;
      @(posedge clk_sys);
      clear <= 1'b0;
      repeat (16384) begin
         @(posedge clk_sys);
         mot.shaft_pos <= mot.shaft_pos + 32'h4;
      end
      tick(3);
      check("z count", z_pulses, 32'd1);
      check("a toggles", a_toggles, exp_a);
   endtask : turn

   task t_abz;
      wr(REG_CTRL, 32'h10);
      turn(32'd5000, 2 * Z_MAX_PPR);
      turn(32'd2000, 4000);
   endtask : t_abz

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      mot.sto_ok = 1'b1;
      repeat (4) @(posedge clk_sys);
      resetn <= 1'b1;
      tick(4);
      t_reset();
      t_func();
      t_alarm();
      t_sto();
      t_abz();
      test_done();
   end

   // Guard against a hang anywhere above
   initial begin
      #3000000;
      bad_count++;
      test_done();
   end
endmodule : servo_output_status_logic_bench

/* File: bench/sos_host_model.sv */
// Purpose: Host reader that counts encoder line activity
// Assumes: Lines are sampled on every rising edge of clk_sys
// Notes:   Counts only, the bench judges the totals
`timescale 1ns/100ps
module sos_host_model (
   input wire logic clk_sys,
   input wire logic clear,
   input wire logic line_a,
   input wire logic line_z,
   output int a_toggles,
   output int z_pulses
);
   logic a_last = 1'b0;

   initial begin
      a_toggles = 0;
      z_pulses = 0;
   end

   // ------------------------------------------------------------
   // Counters
   // ------------------------------------------------------------
   always @(posedge clk_sys) begin
      a_last <= line_a;
      if (clear) begin
         a_toggles <= 0;
         z_pulses <= 0;
      end else begin
         // Any change counts, also a change out of an unknown
         if (line_a !== a_last) a_toggles <= a_toggles + 1;
         if (line_z === 1'b1) z_pulses <= z_pulses + 1;
      end
   end
endmodule : sos_host_model

/* File: hw/sos_abz.sv */
// Purpose: Quadrature A/B/Z emulation from shaft position
// Assumes: Shaft position counts one turn per 2^16 units
// Notes:   Resolution clamped to the maximum ppr
`timescale 1ns/100ps
module sos_abz (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [15:0] res_ppr,
   input wire logic [31:0] shaft_pos,
   output logic phase_a,
   output logic phase_b,
   output logic phase_z
);
   import sos_pkg::*;

   logic [15:0] ppr;
   logic [33:0] quad;
   logic [1:0] q_nxt, q_r;
   logic [15:0] turn_r, turn_nxt;
   logic z_nxt, z_r;

   // Clamp of output resolution
   assign ppr = (res_ppr < 16'(Z_MAX_PPR)) ? res_ppr : 16'(Z_MAX_PPR); // RULE5
   // Four quarter states per ppr line within one turn
   assign quad = 34'({2'b00, shaft_pos[15:0]} * {ppr, 2'b00}) >> 16;

   always_comb begin
      q_nxt = quad[1:0];
      turn_nxt = shaft_pos[31:16];
      z_nxt = (turn_nxt != turn_r); // RULE4
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         q_r <= 2'h0;
         turn_r <= 16'h0;
         z_r <= 1'b0;
      end else begin
         q_r <= q_nxt;
         turn_r <= turn_nxt;
         z_r <= z_nxt;
      end
   end

   // Gray sequence: B leads on rising count, A leads when falling
   assign phase_a = q_r[1]; // RULE20
   assign phase_b = q_r[1] ^ q_r[0]; // RULE20
   assign phase_z = z_r;

endmodule : sos_abz

/* File: hw/sos_pkg.sv */
// Purpose: Shared constants and types for the servo output status block
// Assumes: 25 MHz system clock, register port with one-cycle read latency
// Notes:   Offsets are word addresses on the plain register port
package sos_pkg;

   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 25000000;
   localparam int BLINK_MS = 250;
   localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
   localparam int Z_MAX_PPR = 3000;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_FUNC = 4'h1;
   localparam logic [3:0] REG_INPOS = 4'h2;
   localparam logic [3:0] REG_MOVE = 4'h3;
   localparam logic [3:0] REG_RES = 4'h4;
   localparam logic [3:0] REG_STAT = 4'h5;
   localparam logic [3:0] REG_CODE = 4'h6;
   localparam logic [3:0] REG_ALARM = 4'h7;

   // CTRL fields
   localparam int CTRL_SEL = 0;
   localparam int CTRL_GEN0 = 1;
   localparam int CTRL_GEN2 = 3;
   localparam int CTRL_SRV_REQ = 4;

   // Reset values
   localparam logic [4:0] CTRL_RST = 5'h10;
   localparam logic [15:0] INPOS_RST = 16'h000a;
   localparam logic [15:0] MOVE_RST = 16'h0064;
   localparam logic [15:0] RES_RST = 16'h03e8;

   // Status report codes
   localparam logic [15:0] CODE_INPOS = 16'h0008;
   localparam logic [15:0] CODE_SRVOFF = 16'h0010;
   localparam logic [15:0] CODE_WARN = 16'h0100;
   localparam logic [15:0] CODE_STO = 16'h0400;

   // Output function codes
   localparam logic [3:0] FN_GENERAL = 4'h0;
   localparam logic [3:0] FN_INPOS = 4'h1;
   localparam logic [3:0] FN_WARN = 4'h2;
   localparam logic [3:0] FN_MOVE = 4'h5;
   localparam logic [3:0] FN_SERVO = 4'h8;
   localparam logic [3:0] FN_TORQUE = 4'h9;

   // Alarm bit positions in REG_ALARM
   localparam int ALM_OVERLOAD = 0;
   localparam int ALM_POSERR = 5;

   typedef enum logic [2:0] {
      LED_OFF, LED_RED, LED_MAGENTA, LED_GREEN,
      LED_CYAN, LED_BLUE, LED_WHITE, LED_YELLOW
   } sos_color_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } sos_req_t;

   typedef struct packed {
      logic [31:0] pos_err;
      logic [15:0] speed;
      logic [31:0] shaft_pos;
      logic [5:0] alarms;
      logic [1:0] limits;
      logic [1:0] warn_other;
      logic torque_in;
      logic sto_ok;
   } sos_mot_t;

endpackage : sos_pkg

/* File: hw/sos_top.sv */
// Purpose: Output status logic: assignable outputs, alarm, SAFE_TORQUE_OFF, LED
// Assumes: Inputs synchronous to clk_sys
// Notes:   Registers on a plain word-addressed port
//
// Operation
// (RULE1) Four outputs, fourth fixed to alarm
// (RULE2) Any alarm forces servo off; code still turns servo on for one cycle on SAFE_TORQUE_OFF restore
// (RULE3) Selector zero drives A, B, Z phases
// (RULE4) One Z pulse per shaft turn
// (RULE5) Encoder resolution clamped at 3000 ppr
// (RULE6) Selector one uses per-output function codes
// (RULE7) Function code decode table
// (RULE8) Warning output during any warning
// (RULE9) In-position when within range of target
// (RULE10) In-position drops when deviation exceeds range
// (RULE11) Motion output above speed threshold
// (RULE12) Torque limit output follows input four
// (RULE13) Only assigned functions reach pins
// (RULE14) SAFE_TORQUE_OFF voltage loss: servo off, code 1024
// (RULE15) SAFE_TORQUE_OFF restore clears alarm, servo on
// (RULE16) Seven-colour LED, fixed priority
// (RULE17) Steady, flashing or alternating patterns
// (RULE18) Limit sensor gives warning code 256
// (RULE19) Blink period fixed from clock
// (RULE20) A leads B one way, B the other
`timescale 1ns/100ps
module sos_top (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire sos_pkg::sos_req_t bus_req,
   output logic [31:0] rdata,
   input wire sos_pkg::sos_mot_t mot,
   output logic output_one,
   output logic output_two,
   output logic output_three,
   output logic output_alarm,
   output logic servo_on,
   output logic motor_power_en,
   output logic [2:0] led_color
);
   import sos_pkg::*;

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic rst_s1, rst_n;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [4:0] ctrl_r, ctrl_nxt;
   logic [11:0] func_r, func_nxt;
   logic [15:0] inpos_r, inpos_nxt, move_r, move_nxt, res_r, res_nxt;
   logic [31:0] rdata_nxt;
   logic [15:0] code_r, code_nxt;
   logic srv_r, srv_nxt, sto_prev_r, sto_prev_nxt;
   logic inpos_st_r, inpos_st_nxt;
   logic [2:0] outs_r, outs_nxt;
   logic alarm_r, alarm_nxt, pwr_r, pwr_nxt;
   sos_color_t led_r, led_nxt;
   logic any_alarm, any_warn, sto_act, sto_back, moving, torque;
   logic [31:0] err_abs;
   logic [2:0] fn_val;
   logic pa, pb, pz;

   assign any_alarm = |mot.alarms;
   assign any_warn = (|mot.limits) | (|mot.warn_other); // RULE8 RULE18
   assign sto_act = !mot.sto_ok;
   assign sto_back = mot.sto_ok && !sto_prev_r;
   assign moving = mot.speed > move_r; // RULE11
   assign torque = mot.torque_in; // RULE12
   assign err_abs = mot.pos_err[31] ? -mot.pos_err : mot.pos_err;

   always_comb begin
      ctrl_nxt = ctrl_r;
      func_nxt = func_r;
      inpos_nxt = inpos_r;
      move_nxt = move_r;
      res_nxt = res_r;
      rdata_nxt = 32'h0;
      if (bus_req.wr) begin
         unique case (bus_req.addr)
            REG_CTRL: ctrl_nxt = bus_req.wdata[4:0];
            REG_FUNC: func_nxt = bus_req.wdata[11:0];
            REG_INPOS: inpos_nxt = bus_req.wdata[15:0];
            REG_MOVE: move_nxt = bus_req.wdata[15:0];
            REG_RES: res_nxt = bus_req.wdata[15:0];
            default: ;
         endcase
      end
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            REG_CTRL: rdata_nxt = {27'h0, ctrl_r};
            REG_FUNC: rdata_nxt = {20'h0, func_r};
            REG_INPOS: rdata_nxt = {16'h0, inpos_r};
            REG_MOVE: rdata_nxt = {16'h0, move_r};
            REG_RES: rdata_nxt = {16'h0, res_r};
            REG_STAT: rdata_nxt = {24'h0, pwr_r, inpos_st_r, alarm_r,
                                   srv_r, outs_r, sto_act};
            REG_CODE: rdata_nxt = {16'h0, code_r};
            REG_ALARM: rdata_nxt = {26'h0, mot.alarms};
            default: rdata_nxt = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= CTRL_RST;
         func_r <= 12'h0;
         inpos_r <= INPOS_RST;
         move_r <= MOVE_RST;
         res_r <= RES_RST;
         rdata <= 32'h0;
      end else begin
         ctrl_r <= ctrl_nxt;
         func_r <= func_nxt;
         inpos_r <= inpos_nxt;
         move_r <= move_nxt;
         res_r <= res_nxt;
         rdata <= rdata_nxt;
      end
   end

   // ------------------------------------------------------------
   // Encoder emulation
   // ------------------------------------------------------------
   sos_abz u_abz (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .res_ppr(res_r),
      .shaft_pos(mot.shaft_pos),
      .phase_a(pa),
      .phase_b(pb),
      .phase_z(pz)
   );

   // ------------------------------------------------------------
   // Servo state, SAFE_TORQUE_OFF and output mux
   // ------------------------------------------------------------
   always_comb begin
      // Window check first, the status code below reads it
      inpos_st_nxt = (err_abs <= {16'h0, inpos_r}); // RULE9 RULE10
      alarm_nxt = any_alarm && !sto_back; // RULE1 RULE15
      srv_nxt = srv_r;
      sto_prev_nxt = mot.sto_ok;
      pwr_nxt = mot.sto_ok; // RULE14
      code_nxt = code_r;
      if (sto_act) begin
         srv_nxt = 1'b0; // RULE14
         code_nxt = CODE_STO; // RULE14
      end else if (sto_back) begin
         srv_nxt = 1'b1; // RULE15
         code_nxt = CODE_INPOS;
      end else if (any_alarm) begin
         srv_nxt = 1'b0; // RULE2
      end else begin
         srv_nxt = ctrl_r[CTRL_SRV_REQ];
         if (|mot.limits)
            code_nxt = CODE_WARN; // RULE18
         else if (!srv_nxt)
            code_nxt = CODE_SRVOFF;
         else if (inpos_st_nxt)
            code_nxt = CODE_INPOS;
      end
   end

   // Per-output function decode
   for (genvar i = 0; i < 3; i++) begin : g_fn
      always_comb begin
         unique case (func_r[i*4 +: 4]) // RULE7 RULE13
            FN_GENERAL: fn_val[i] = ctrl_r[CTRL_GEN0 + i];
            FN_INPOS: fn_val[i] = inpos_st_r;
            FN_WARN: fn_val[i] = any_warn;
            FN_MOVE: fn_val[i] = moving;
            FN_SERVO: fn_val[i] = srv_r;
            FN_TORQUE: fn_val[i] = torque;
            default: fn_val[i] = 1'b0;
         endcase
      end
   end

   always_comb begin
      if (!ctrl_r[CTRL_SEL])
         outs_nxt = {pz, pb, pa}; // RULE3
      else
         outs_nxt = fn_val; // RULE6
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         srv_r <= 1'b0;
         // Idle level of the SAFE_TORQUE_OFF input, so no false restore after reset
         sto_prev_r <= 1'b1;
         pwr_r <= 1'b0;
         code_r <= CODE_SRVOFF;
         inpos_st_r <= 1'b0;
         alarm_r <= 1'b0;
         outs_r <= 3'h0;
      end else begin
         srv_r <= srv_nxt;
         sto_prev_r <= sto_prev_nxt;
         pwr_r <= pwr_nxt;
         code_r <= code_nxt;
         inpos_st_r <= inpos_st_nxt;
         alarm_r <= alarm_nxt;
         outs_r <= outs_nxt;
      end
   end

   // ------------------------------------------------------------
   // Status LED
   // ------------------------------------------------------------
   // One divider serves flash and alternate phases
   logic [22:0] blink_cnt_r, blink_cnt_nxt;
   logic phase_r, phase_nxt;

   always_comb begin
      blink_cnt_nxt = blink_cnt_r + 23'h1;
      phase_nxt = phase_r;
      if (blink_cnt_r == 23'(BLINK_CYC - 1)) begin // RULE19
         blink_cnt_nxt = 23'h0;
         phase_nxt = !phase_r;
      end
      // Priority order from top row downward
      if (sto_act)
         led_nxt = LED_WHITE; // RULE16 RULE17
      else if (|mot.alarms[4:0])
         led_nxt = phase_r ? LED_RED : LED_YELLOW;
      else if (mot.alarms[ALM_POSERR])
         led_nxt = phase_r ? LED_RED : LED_OFF;
      else if (!srv_r)
         led_nxt = LED_BLUE;
      else if (any_warn)
         led_nxt = phase_r ? LED_MAGENTA : LED_CYAN;
      else if (torque)
         led_nxt = phase_r ? LED_GREEN : LED_OFF;
      else
         led_nxt = LED_GREEN;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         blink_cnt_r <= 23'h0;
         phase_r <= 1'b0;
         led_r <= LED_OFF;
      end else begin
         blink_cnt_r <= blink_cnt_nxt;
         phase_r <= phase_nxt;
         led_r <= led_nxt;
      end
   end

   assign output_one = outs_r[0];
   assign output_two = outs_r[1];
   assign output_three = outs_r[2];
   assign output_alarm = alarm_r;
   assign servo_on = srv_r;
   assign motor_power_en = pwr_r;
   assign led_color = led_r;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_sto_drop; $fell(mot.sto_ok); endsequence
   sequence s_sto_rise; $rose(mot.sto_ok); endsequence

   AST_ALARM_SRV: assert property (any_alarm && !sto_back |=> !srv_r) // RULE2
      else $error("servo stayed on during alarm");
   AST_ALARM_OUT: assert property (any_alarm && !sto_back |=> output_alarm) // RULE1
      else $error("alarm output missing");
   AST_STO_OFF: assert property (s_sto_drop |=> !srv_r && !motor_power_en) // RULE14
      else $error("SAFE_TORQUE_OFF did not cut power");
   AST_STO_CODE: assert property (s_sto_drop |=> code_r == CODE_STO) // RULE14
      else $error("SAFE_TORQUE_OFF code wrong");
   AST_STO_BACK: assert property (s_sto_rise |=> srv_r && !output_alarm) // RULE15
      else $error("SAFE_TORQUE_OFF recovery failed");
   AST_ENC: assert property (!ctrl_r[CTRL_SEL] |=> output_one == $past(pa)) // RULE3
      else $error("encoder mode not on outputs");
   AST_INPOS: assert property (ctrl_r[CTRL_SEL] && // RULE9
      func_r[3:0] == FN_INPOS
      && $stable(func_r) |=> output_one == $past(inpos_st_r))
      else $error("in-position output wrong");
   AST_UNUSED: assert property (ctrl_r[CTRL_SEL] && // RULE13
      func_r[11:8] == 4'h3
      && $stable(ctrl_r) |=> !output_three)
      else $error("unused code drove pin");
   AST_LED_ALM: assert property (!sto_act && // RULE16 RULE17
      |mot.alarms[4:0]
      |=> led_color != LED_OFF && led_color != LED_BLUE)
      else $error("alarm colour not shown");
   AST_LED_STO: assert property (sto_act |=> led_color == LED_WHITE) // RULE16
      else $error("SAFE_TORQUE_OFF colour not shown");

endmodule : sos_top
